// File: core/rpc_rx_chan.sv
// one receive channel: write and read clock selection around the phase compensation fifo
`timescale 1ns/1ns
`default_nettype none
module rpc_rx_chan
    import rpc_pkg::*;
#(
    parameter int DATA_W = RPC_DATA_W,
    parameter int STAT_W = RPC_STAT_W,
    parameter int DEPTH = RPC_FIFO_DEPTH,
    parameter int CHAN_INDEX = 0
) (
    input wire logic mclk, // system clock, 20 MHz
    input wire logic resetn, // synchronous reset, active low
    input wire rpc_cfg_e cfg_mode, // channel configuration
    input wire logic byte_ser_en, // byte serializer in use
    input wire logic direct_pma, // direct pma mode
    input wire logic user_rd_en, // user read clock selected
    input wire logic tx_pclk, // transmit parallel clock pin
    input wire logic rec_clk, // recovered clock pin
    input wire logic core_clk, // own block bonded core clock pin
    input wire logic master_core_clk, // master block bonded core clock pin
    input wire logic user_rd_clk, // user read clock pin
    input wire logic [DATA_W-1:0] rx_data, // parallel receive data
    input wire logic [STAT_W-1:0] rx_stat, // receive status
    output logic [DATA_W-1:0] fab_data, // data handed to the fabric
    output logic [STAT_W-1:0] fab_stat, // status handed to the fabric
    output logic fab_valid, // one-cycle pulse per delivered word
    output logic rd_tick_out, // read side clock edge, for fabric capture
    output logic overflow, // sticky: write found fifo full
    output logic underrun, // sticky: read found fifo empty
    input wire logic err_clear, // clears both sticky flags
    output logic chan_is_mgmt, // channel is a clock management channel
    input wire logic pll_use_en, // spare pll drives a fabric clock
    input wire logic pll_pfd_pdn, // pfd power-down
    input wire logic [1:0] pll_bw_sel, // pll bandwidth
    output logic pll_locked, // spare pll lock status
    output logic pll_clk_out // spare pll fabric clock
);
    localparam int FW = DATA_W + STAT_W;

    typedef struct packed {
        logic [RPC_NPIN-1:0][RPC_SYNC_STAGES-1:0] sync;
        logic [RPC_NPIN-1:0] lvl;
        logic half;
        logic ovf;
        logic unf;
        logic [DATA_W-1:0] dout;
        logic [STAT_W-1:0] sout;
        logic dvalid;
        logic [RPC_LOCK_W-1:0] lock_cnt;
        logic locked;
        logic pclk;
    } rpc_chan_s;

    rpc_chan_s st;
    rpc_chan_s next_st;
    logic [RPC_NPIN-1:0] pins;
    logic [RPC_NPIN-1:0] edge_rise;
    logic src_tick;
    logic wr_tick;
    logic rd_tick;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [FW-1:0] fifo_out_data;
    logic [RPC_LOCK_W-1:0] lock_target;

    assign pins = {user_rd_clk, master_core_clk, core_clk, rec_clk, tx_pclk};

    // rising edge only once the second and third stages agree on the new level
    always_comb begin
        for (int i = 0; i < RPC_NPIN; i++) begin
            edge_rise[i] = (st.sync[i][1] == st.sync[i][2]) && st.sync[i][2] && !st.lvl[i];
        end
    end

    // write clock source: direct pma never bonds, so it stays on its own recovered clock
    always_comb begin
        if (direct_pma) begin
            src_tick = edge_rise[RPC_PIN_RECCLK];
        end else begin
            case (cfg_mode)
                RPC_NB_RATEMATCH: src_tick = edge_rise[RPC_PIN_TXPCLK];
                RPC_NB_PLAIN: src_tick = edge_rise[RPC_PIN_RECCLK];
                RPC_BOND_X4: src_tick = edge_rise[RPC_PIN_CORECLK];
                RPC_BOND_X8: src_tick = edge_rise[RPC_PIN_MASTERCLK];
                default: src_tick = 1'b0;
            endcase
        end
    end

    // byte serializer halves the chosen source: every second edge writes
    assign wr_tick = src_tick && (!byte_ser_en || st.half);

    // read side: own recovered clock in direct pma, else user clock when enabled
    always_comb begin
        if (direct_pma) begin
            rd_tick = edge_rise[RPC_PIN_RECCLK];
        end else if (user_rd_en) begin
            rd_tick = edge_rise[RPC_PIN_USERRD];
        end else begin
            rd_tick = wr_tick;
        end
    end

    always_comb begin
        case (pll_bw_sel)
            RPC_BW_LOW: lock_target = RPC_LOCK_LOW_BW;
            RPC_BW_MED: lock_target = RPC_LOCK_MED_BW;
            default: lock_target = RPC_LOCK_HIGH_BW;
        endcase
    end

    rpc_fifo #(
        .WIDTH(FW),
        .DEPTH(DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .resetn(resetn),
        .in_valid(wr_tick),
        .in_ready(fifo_in_ready),
        .in_data({rx_stat, rx_data}),
        .out_valid(fifo_out_valid),
        .out_ready(rd_tick),
        .out_data(fifo_out_data)
    );

    always_comb begin
        next_st = st;
        for (int i = 0; i < RPC_NPIN; i++) begin
            next_st.sync[i] = {st.sync[i][1:0], pins[i]};
            if (st.sync[i][1] == st.sync[i][2]) begin
                next_st.lvl[i] = st.sync[i][2];
            end
        end
        if (src_tick && byte_ser_en) begin
            next_st.half = !st.half;
        end else if (!byte_ser_en) begin
            next_st.half = 1'b0;
        end
        // a mismatched read clock shows here; the set beats a clear in the same cycle
        if (err_clear) begin
            next_st.ovf = 1'b0;
            next_st.unf = 1'b0;
        end
        if (wr_tick && !fifo_in_ready) begin
            next_st.ovf = 1'b1;
        end
        if (rd_tick && !fifo_out_valid) begin
            next_st.unf = 1'b1;
        end
        // fabric side is registered on the read tick itself
        next_st.dvalid = rd_tick && fifo_out_valid;
        if (rd_tick && fifo_out_valid) begin
            {next_st.sout, next_st.dout} = fifo_out_data;
        end
        // spare pll: lock after a bandwidth-dependent number of transmit clock edges
        if (!pll_use_en || pll_pfd_pdn) begin
            next_st.lock_cnt = '0;
            next_st.locked = 1'b0;
        end else if (edge_rise[RPC_PIN_TXPCLK] && !st.locked) begin
            next_st.lock_cnt = st.lock_cnt + 1'b1;
            if (st.lock_cnt + 1'b1 >= lock_target) begin
                next_st.locked = 1'b1;
            end
        end
        // the transmit parallel clock already runs at data rate over channel width
        next_st.pclk = st.locked && pll_use_en && !pll_pfd_pdn
            && st.lvl[RPC_PIN_TXPCLK];
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign fab_data = st.dout;
    assign fab_stat = st.sout;
    assign fab_valid = st.dvalid;
    assign rd_tick_out = rd_tick;
    assign overflow = st.ovf;
    assign underrun = st.unf;
    assign pll_locked = st.locked;
    assign pll_clk_out = st.pclk;
    assign chan_is_mgmt = (CHAN_INDEX >= RPC_REGULAR_CHANNELS);

    // placement of the channel inside its block
    AST_CHAN_RANGE: assert property (@(posedge mclk) disable iff (!resetn)
        CHAN_INDEX < RPC_BLOCK_CHANNELS) else $error("channel index outside block");

    // sticky error flags: a set in the same cycle beats a clear
    AST_OVF_SET: assert property (@(posedge mclk) disable iff (!resetn)
        (wr_tick && !fifo_in_ready) |=> overflow) else $error("overflow not flagged");

    AST_OVF_STICKY: assert property (@(posedge mclk) disable iff (!resetn)
        (overflow && !err_clear) |=> overflow) else $error("overflow flag dropped");

    AST_OVF_CLEAR: assert property (@(posedge mclk) disable iff (!resetn)
        (err_clear && !(wr_tick && !fifo_in_ready)) |=> !overflow)
        else $error("overflow flag not cleared");

    AST_UNF_SET: assert property (@(posedge mclk) disable iff (!resetn)
        (rd_tick && !fifo_out_valid) |=> underrun) else $error("underrun not flagged");

    AST_UNF_STICKY: assert property (@(posedge mclk) disable iff (!resetn)
        (underrun && !err_clear) |=> underrun) else $error("underrun flag dropped");

    AST_UNF_CLEAR: assert property (@(posedge mclk) disable iff (!resetn)
        (err_clear && !(rd_tick && !fifo_out_valid)) |=> !underrun)
        else $error("underrun flag not cleared");

    // write clock selection
    AST_SRC_RATEMATCH: assert property (@(posedge mclk) disable iff (!resetn)
        (cfg_mode == RPC_NB_RATEMATCH && !direct_pma && !byte_ser_en
         && edge_rise[RPC_PIN_TXPCLK]) |-> wr_tick) else $error("tx clock not writing");

    AST_RATEMATCH_ONLY: assert property (@(posedge mclk) disable iff (!resetn)
        (cfg_mode == RPC_NB_RATEMATCH && !direct_pma && !edge_rise[RPC_PIN_TXPCLK])
        |-> !wr_tick) else $error("rate matcher write from a foreign clock");

    AST_SRC_PLAIN: assert property (@(posedge mclk) disable iff (!resetn)
        (cfg_mode == RPC_NB_PLAIN && !direct_pma && !byte_ser_en
         && edge_rise[RPC_PIN_RECCLK]) |-> wr_tick) else $error("recovered clock not writing");

    AST_PLAIN_ONLY: assert property (@(posedge mclk) disable iff (!resetn)
        (cfg_mode == RPC_NB_PLAIN && !direct_pma && !edge_rise[RPC_PIN_RECCLK])
        |-> !wr_tick) else $error("plain write from a foreign clock");

    AST_SRC_X4: assert property (@(posedge mclk) disable iff (!resetn)
        (cfg_mode == RPC_BOND_X4 && !direct_pma) |-> (src_tick == edge_rise[RPC_PIN_CORECLK]))
        else $error("x4 write clock wrong");

    AST_SRC_X8: assert property (@(posedge mclk) disable iff (!resetn)
        (cfg_mode == RPC_BOND_X8 && !direct_pma) |-> (src_tick == edge_rise[RPC_PIN_MASTERCLK]))
        else $error("x8 write clock wrong");

    AST_BYTE_OFF: assert property (@(posedge mclk) disable iff (!resetn)
        !byte_ser_en |-> (wr_tick == src_tick)) else $error("write clock halved without serializer");

    AST_HALF_SKIP: assert property (@(posedge mclk) disable iff (!resetn)
        (byte_ser_en && wr_tick) |=> !st.half) else $error("byte serializer did not halve write clock");

    AST_HALF_ARM: assert property (@(posedge mclk) disable iff (!resetn)
        (byte_ser_en && src_tick && !wr_tick) |=> st.half)
        else $error("skipped edge did not arm the next write");

    // direct pma and read clock selection
    AST_PMA_READ: assert property (@(posedge mclk) disable iff (!resetn)
        direct_pma |-> (rd_tick == edge_rise[RPC_PIN_RECCLK]))
        else $error("pma read clock wrong");

    AST_PMA_WRITE: assert property (@(posedge mclk) disable iff (!resetn)
        direct_pma |-> (src_tick == edge_rise[RPC_PIN_RECCLK]))
        else $error("pma write clock wrong");

    AST_PMA_NOBOND: assert property (@(posedge mclk) disable iff (!resetn)
        (direct_pma && edge_rise[RPC_PIN_CORECLK] && !edge_rise[RPC_PIN_RECCLK]) |-> !src_tick)
        else $error("pma lane followed bonded clock");

    AST_USER_READ: assert property (@(posedge mclk) disable iff (!resetn)
        (user_rd_en && !direct_pma) |-> (rd_tick == edge_rise[RPC_PIN_USERRD]))
        else $error("user read clock ignored");

    AST_USER_WRITE: assert property (@(posedge mclk) disable iff (!resetn)
        (user_rd_en && !direct_pma && cfg_mode == RPC_NB_PLAIN && !byte_ser_en)
        |-> (wr_tick == edge_rise[RPC_PIN_RECCLK]))
        else $error("user read clock moved the write side");

    AST_AUTO_READ: assert property (@(posedge mclk) disable iff (!resetn)
        (!direct_pma && !user_rd_en) |-> (rd_tick == wr_tick))
        else $error("automatic read clock differs from write clock");

    // fabric hand-over
    AST_FAB_VALID: assert property (@(posedge mclk) disable iff (!resetn)
        (rd_tick && fifo_out_valid) |=> fab_valid ##1 !fab_valid)
        else $error("read word not delivered");

    AST_NO_EMPTY_VALID: assert property (@(posedge mclk) disable iff (!resetn)
        (rd_tick && !fifo_out_valid) |=> !fab_valid)
        else $error("empty read delivered a word");

    AST_VALID_NEEDS_TICK: assert property (@(posedge mclk) disable iff (!resetn)
        !(rd_tick && fifo_out_valid) |=> !fab_valid)
        else $error("word delivered without a read");

    // spare pll
    AST_PLL_PDN: assert property (@(posedge mclk) disable iff (!resetn)
        pll_pfd_pdn |=> !pll_locked ##1 !pll_clk_out)
        else $error("pll stayed locked in power-down");

    AST_PLL_CLK: assert property (@(posedge mclk) disable iff (!resetn)
        !pll_locked |=> !pll_clk_out) else $error("pll clock ran unlocked");

    AST_PLL_OFF: assert property (@(posedge mclk) disable iff (!resetn)
        !pll_use_en |=> !pll_locked) else $error("unused pll reports lock");

    AST_LOCK_HOLD: assert property (@(posedge mclk) disable iff (!resetn)
        (pll_locked && pll_use_en && !pll_pfd_pdn) |=> pll_locked)
        else $error("pll lost lock while running");

    AST_PLL_COUNT: assert property (@(posedge mclk) disable iff (!resetn)
        (!pll_locked && !edge_rise[RPC_PIN_TXPCLK]) |=> !pll_locked)
        else $error("pll locked without a transmit clock edge");
endmodule
`default_nettype wire

// File: pkg/rpc_pkg.sv
// constants and types for the receive phase compensation fifo clocking block
package rpc_pkg;
    typedef enum logic [1:0] {
        RPC_NB_RATEMATCH = 2'b00,
        RPC_NB_PLAIN = 2'b01,
        RPC_BOND_X4 = 2'b10,
        RPC_BOND_X8 = 2'b11
    } rpc_cfg_e;

    localparam int RPC_NPIN = 5;
    localparam int RPC_PIN_TXPCLK = 0;
    localparam int RPC_PIN_RECCLK = 1;
    localparam int RPC_PIN_CORECLK = 2;
    localparam int RPC_PIN_MASTERCLK = 3;
    localparam int RPC_PIN_USERRD = 4;
    localparam int RPC_SYNC_STAGES = 3;

    localparam int RPC_REGULAR_CHANNELS = 4;
    localparam int RPC_MGMT_CHANNELS = 2;
    localparam int RPC_BLOCK_CHANNELS = RPC_REGULAR_CHANNELS + RPC_MGMT_CHANNELS;

    localparam int RPC_FIFO_DEPTH = 16;
    localparam int RPC_DATA_W = 16;
    localparam int RPC_STAT_W = 4;

    // lock time of the spare pll counted in transmit clock edges, per bandwidth
    localparam int RPC_LOCK_W = 7;
    localparam logic [6:0] RPC_LOCK_LOW_BW = 7'h40;
    localparam logic [6:0] RPC_LOCK_MED_BW = 7'h20;
    localparam logic [6:0] RPC_LOCK_HIGH_BW = 7'h10;
    localparam logic [1:0] RPC_BW_LOW = 2'h0;
    localparam logic [1:0] RPC_BW_MED = 2'h1;
endpackage

// File: core/rpc_fifo.sv
// small synchronous fifo holding received words between write and read ticks
`timescale 1ns/1ns
`default_nettype none
module rpc_fifo
    import rpc_pkg::*;
#(
    parameter int WIDTH = RPC_DATA_W + RPC_STAT_W,
    parameter int DEPTH = RPC_FIFO_DEPTH
) (
    input wire logic mclk, // system clock
    input wire logic resetn, // synchronous reset, active low
    input wire logic in_valid, // write request
    output logic in_ready, // room for a word
    input wire logic [WIDTH-1:0] in_data, // word to store
    output logic out_valid, // word available
    input wire logic out_ready, // read request
    output logic [WIDTH-1:0] out_data // oldest word
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } rpc_fifo_s;

    rpc_fifo_s st;
    rpc_fifo_s next_st;
    logic full;
    logic empty;

    // extra pointer bit tells full from empty without a counter
    assign empty = (st.wp == st.rp);
    assign full = (st.wp[AW] != st.rp[AW]) && (st.wp[AW-1:0] == st.rp[AW-1:0]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = st.mem[st.rp[AW-1:0]];

    always_comb begin
        next_st = st;
        if (in_valid && !full) begin
            next_st.mem[st.wp[AW-1:0]] = in_data;
            next_st.wp = st.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            next_st.rp = st.rp + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    AST_FIFO_NO_WRAP: assert property (@(posedge mclk) disable iff (!resetn)
        full |=> !empty) else $error("fifo lost its contents while full");
endmodule
`default_nettype wire

// File: verification/rpc_fabric_model.sv
// fabric-side user logic model: runs the user read clock and captures delivered words
`timescale 1ns/1ns
`default_nettype none
module rpc_fabric_model
    import rpc_pkg::*;
(
    input wire logic mclk, // system clock
    input wire logic resetn, // synchronous reset, active low
    input wire logic rd_go, // request one read clock period
    output logic user_rd_clk, // user read clock pin
    input wire logic fab_valid, // delivered word pulse
    input wire logic [RPC_DATA_W-1:0] fab_data, // delivered data
    input wire logic [RPC_STAT_W-1:0] fab_stat, // delivered status
    output logic [RPC_DATA_W+RPC_STAT_W-1:0] got_word, // last captured word
    output logic [7:0] got_cnt // words captured
);
    logic [3:0] ph;
    // clean clock derived from the common timebase, so zero offset; stands still when idle
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ph <= 4'h0;
        end else if (ph != 4'h0) begin
            ph <= (ph == 4'h8) ? 4'h0 : ph + 4'h1;
        end else if (rd_go) begin
            ph <= 4'h1;
        end
    end
    assign user_rd_clk = (ph != 4'h0) && (ph <= 4'h4);
    // capture in the same domain that drives the fifo read side
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            got_word <= '0;
            got_cnt <= 8'h00;
        end else if (fab_valid) begin
            got_word <= {fab_stat, fab_data};
            got_cnt <= got_cnt + 8'h01;
        end
    end
endmodule
`default_nettype wire

// File: verification/rx_phase_comp_fifo_clocking_bench.sv
// testbench for one receive channel with its fabric-side partner
`timescale 1ns/1ns
`default_nettype none
module rx_phase_comp_fifo_clocking_bench
    import rpc_pkg::*;
;
    logic mclk, resetn, byte_ser_en, direct_pma, user_rd_en, err_clear, rd_go, user_rd_clk;
    rpc_cfg_e cfg_mode;
    logic [3:0] pins;
    logic [19:0] rx_word, got_word;
    logic [15:0] fab_data;
    logic [3:0] fab_stat;
    logic fab_valid, rd_tick_out, overflow, underrun, chan_is_mgmt, pll_locked, pll_clk_out;
    logic pll_use_en, pll_pfd_pdn;
    logic [1:0] pll_bw_sel;
    logic [7:0] got_cnt;
    int mismatches = 0;
    int tests_run = 0;

    rpc_rx_chan DUT (.mclk(mclk), .resetn(resetn), .cfg_mode(cfg_mode),
        .byte_ser_en(byte_ser_en), .direct_pma(direct_pma), .user_rd_en(user_rd_en),
        .tx_pclk(pins[0]), .rec_clk(pins[1]), .core_clk(pins[2]), .master_core_clk(pins[3]),
        .user_rd_clk(user_rd_clk), .rx_data(rx_word[15:0]), .rx_stat(rx_word[19:16]),
        .fab_data(fab_data), .fab_stat(fab_stat), .fab_valid(fab_valid),
        .rd_tick_out(rd_tick_out), .overflow(overflow), .underrun(underrun),
        .err_clear(err_clear), .chan_is_mgmt(chan_is_mgmt), .pll_use_en(pll_use_en),
        .pll_pfd_pdn(pll_pfd_pdn), .pll_bw_sel(pll_bw_sel), .pll_locked(pll_locked),
        .pll_clk_out(pll_clk_out));
    rpc_fabric_model partner (.mclk(mclk), .resetn(resetn), .rd_go(rd_go),
        .user_rd_clk(user_rd_clk), .fab_valid(fab_valid), .fab_data(fab_data),
        .fab_stat(fab_stat), .got_word(got_word), .got_cnt(got_cnt));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #5;
    endtask
    task automatic chk(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask
    task automatic do_reset();
        resetn = 1'b0;
        cyc(2);
        resetn = 1'b1;
        cyc(1);
    endtask
    // one pin edge: low gaps of 4 cycles keep the 3-stage synchroniser honest
    task automatic wr(input int p, input logic [19:0] w);
        rx_word = w;
        pins[p] = 1'b1;
        cyc(4);
        pins[p] = 1'b0;
        cyc(4);
    endtask
    task automatic rd();
        rd_go = 1'b1;
        cyc(1);
        rd_go = 1'b0;
        cyc(10);
    endtask

    task automatic t_reset();
        chk(fab_valid === 1'b0, "valid at reset");
        chk(overflow === 1'b0 && underrun === 1'b0, "flags at reset");
        chk(pll_locked === 1'b0 && fab_data === 16'h0000, "outputs at reset");
        chk(chan_is_mgmt === 1'b0, "channel 0 is regular");
        $display("reset test done");
    endtask
    task automatic t_auto();
        do_reset();
        wr(0, 20'h1_00a1);
        chk(underrun === 1'b1, "empty read on shared tick");
        wr(1, 20'h2_00b2);
        chk(got_cnt === 8'h00, "recovered pin ignored");
        rx_word = 20'h3_00c3;
        pins[0] = 1'b1;
        cyc(3);
        chk(rd_tick_out === 1'b1, "read tick on third synchroniser edge");
        cyc(1);
        chk(rd_tick_out === 1'b0, "read tick lasts one cycle");
        pins[0] = 1'b0;
        cyc(4);
        chk(got_word === 20'h1_00a1 && got_cnt === 8'h01, "auto read word");
        $display("automatic read test done");
    endtask
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            do_reset();
            cfg_mode = rpc_cfg_e'(m);
            user_rd_en = 1'b1;
            for (int p = 0; p < 4; p++) begin
                if (p != m) wr(p, 20'h9_0000 + 20'(p));
            end
            wr(m, 20'h5_0000 + 20'(m));
            chk(got_cnt === 8'h00, "no read without user clock");
            rd();
            chk(got_word === 20'h5_0000 + 20'(m), "word from the selected pin");
            chk(got_cnt === 8'h01, "one word from the selected pin");
            chk(underrun === 1'b0 && overflow === 1'b0, "clean transfer");
        end
        $display("write clock selection test done");
    endtask
    task automatic t_byteser();
        do_reset();
        cfg_mode = RPC_NB_PLAIN;
        byte_ser_en = 1'b1;
        wr(1, 20'h6_1111);
        wr(1, 20'h7_2222);
        rd();
        chk(got_word === 20'h7_2222 && got_cnt === 8'h01, "halved clock word");
        rd();
        chk(underrun === 1'b1 && got_cnt === 8'h01, "only one word stored");
        byte_ser_en = 1'b0;
        $display("byte serializer test done");
    endtask
    task automatic t_overflow();
        do_reset();
        cfg_mode = RPC_NB_RATEMATCH;
        for (int i = 0; i < 17; i++) begin
            if (i == 16) chk(overflow === 1'b0, "full fifo not overflowed");
            wr(0, 20'h0_1000 + 20'(i));
        end
        chk(overflow === 1'b1, "overflow flag");
        for (int i = 0; i < 16; i++) begin
            rd();
            chk(got_word === 20'h0_1000 + 20'(i), "drain order");
        end
        chk(underrun === 1'b0, "no early underrun");
        rd();
        chk(underrun === 1'b1 && got_cnt === 8'h10, "underrun flag");
        err_clear = 1'b1;
        cyc(1);
        err_clear = 1'b0;
        cyc(1);
        chk(overflow === 1'b0 && underrun === 1'b0, "flags cleared");
        $display("overflow test done");
    endtask
    task automatic t_direct();
        do_reset();
        cfg_mode = RPC_BOND_X4;
        direct_pma = 1'b1;
        wr(2, 20'h8_0001);
        wr(1, 20'h8_0002);
        chk(underrun === 1'b1 && got_cnt === 8'h00, "own recovered tick");
        wr(1, 20'h8_0003);
        rd();
        chk(got_word === 20'h8_0002 && got_cnt === 8'h01, "direct word");
        direct_pma = 1'b0;
        $display("direct mode test done");
    endtask
    // every bandwidth: one edge short of its count, then exactly on it
    task automatic t_lock(input logic [1:0] bw, input int n);
        do_reset();
        pll_use_en = 1'b1;
        pll_bw_sel = bw;
        repeat (n - 1) wr(0, 20'h0_0000);
        chk(pll_locked === 1'b0, "not locked one edge early");
        wr(0, 20'h0_0000);
        chk(pll_locked === 1'b1, "locked on the last edge");
    endtask
    task automatic t_pll();
        t_lock(RPC_BW_LOW, int'(RPC_LOCK_LOW_BW));
        t_lock(RPC_BW_MED, int'(RPC_LOCK_MED_BW));
        t_lock(2'h2, int'(RPC_LOCK_HIGH_BW));
        pins[0] = 1'b1;
        cyc(5);
        chk(pll_clk_out === 1'b1, "clock follows transmit pin");
        pins[0] = 1'b0;
        cyc(5);
        chk(pll_clk_out === 1'b0, "clock low");
        pll_pfd_pdn = 1'b1;
        cyc(2);
        chk(pll_locked === 1'b0, "power-down drops lock");
        pll_pfd_pdn = 1'b0;
        pll_use_en = 1'b0;
        $display("spare pll test done");
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        resetn = 1'b0;
        cfg_mode = RPC_NB_RATEMATCH;
        {byte_ser_en, direct_pma, user_rd_en, err_clear, rd_go} = 5'h00;
        {pll_use_en, pll_pfd_pdn, pll_bw_sel} = 4'h0;
        pins = 4'h0;
        rx_word = 20'h0_0000;
        cyc(6);
        resetn = 1'b1;
        cyc(1);
        t_reset();
        t_auto();
        t_modes();
        user_rd_en = 1'b1;
        t_byteser();
        t_overflow();
        t_direct();
        t_pll();
        end_of_test();
    end
    // whole run needs under 2000 cycles
    initial begin
        #(50 * 5000);
        mismatches++;
        end_of_test();
    end
endmodule
`default_nettype wire
